// file: hdl/dlr_cfg.svh
`ifndef DLR_CFG_SVH
`define DLR_CFG_SVH

// ****************************************************************
// Clock and guard timing
// ****************************************************************
// Clock rate in MHz
`define DLR_CLK_MHZ        125
// Guard time, tone present, in microseconds
`define DLR_GTP_US         30000
// Guard time, tone absent, in microseconds
`define DLR_GTA_US         30000
// Guard counts in clock cycles
`define DLR_GTP_CYC        (`DLR_GTP_US * `DLR_CLK_MHZ)
`define DLR_GTA_CYC        (`DLR_GTA_US * `DLR_CLK_MHZ)

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DLR_OFF_RXDATA     12'h000
`define DLR_OFF_STATUS     12'h004
`define DLR_OFF_MASK       12'h008
`define DLR_OFF_CTRL       12'h00c
`define DLR_OFF_LEVEL      12'h010

// ****************************************************************
// Field positions and reset values
// ****************************************************************
// Status and mask bits
`define DLR_ST_NEWDIG      0
`define DLR_ST_TONEEND     1
`define DLR_ST_REJECT      2
`define DLR_ST_W           3
// Control bit, control and mask reset values
`define DLR_CTRL_EN        0
`define DLR_CTRL_RST       1'h1
`define DLR_MASK_RST       3'h0
// Live level bits
`define DLR_LV_EARLY       0
`define DLR_LV_DELAYED     1
`define DLR_LV_GUARD       2

`endif

// file: hdl/dlr_pkg.sv
package dlr_pkg;

  // Digit qualification states
  typedef enum logic [1:0] {
    IDLE,
    PRESENT_WAIT,
    LATCHED,
    ABSENT_WAIT
  } dlr_state_type;

  // Four-bit decoded digit
  typedef logic [3:0] dlr_digit_type;

endpackage

// file: hdl/dlr_qual_timer.sv
`timescale 1ns/1ps

// ****************************************************************
// Guard timer: done once run has held for CYCLES cycles
// ****************************************************************
module dlr_qual_timer #(
  parameter int unsigned CYCLES = 4
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done
);

  logic [31:0] cnt_r;

  // Count while run holds, stop at CYCLES - 1, restart when it drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
    end else if (!run) begin
      cnt_r <= 32'h0;
    end else if (cnt_r != CYCLES - 32'h1) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Expiry flag, high in the last cycle of the guard span
  assign done = run && (cnt_r == CYCLES - 32'h1);

endmodule

// file: hdl/dlr_sticky_flag.sv
`timescale 1ns/1ps

// ****************************************************************
// Sticky event flag, set wins over clear
// ****************************************************************
module dlr_sticky_flag (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_r;

  // Hold until cleared; a same-cycle set keeps it high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= set | (flag_r & ~clr);
    end
  end

  assign flag = flag_r;

endmodule

// file: hdl/dtmf_rx_digit_latch.sv
// Functional notes
// - Short tone burst: no latch, no digit
// - Qualified tone: latch decoded digit code
// - After tone end, digit held until next
// - Short dropout keeps tone and digit
// - Early flag follows raw tone detection
// - Receive register holds four-bit code
// - New digit raises irq; status access clears
// - Accept 40 ms tones, reject 20 ms
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "dlr_cfg.svh"

module dtmf_rx_digit_latch #(
  parameter int unsigned GUARD_PRESENT_CYC = `DLR_GTP_CYC,
  parameter int unsigned GUARD_ABSENT_CYC  = `DLR_GTA_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // Tone detector front end
  input  wire logic        toneValid,
  input  wire logic [3:0]  toneCode,
  // Steering and data outputs
  output logic             earlyToneFlag,
  output logic             steerGuardPin,
  output logic             delayedSteer,
  output logic [3:0]       rxDigitBits,
  output logic             newDigitIrq,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dlr_pkg::dlr_state_type  state_r;
  dlr_pkg::dlr_state_type  state_nxt;
  dlr_pkg::dlr_digit_type  digit_r;

  logic                    early_r;
  logic                    delayed_r;
  logic                    guard_r;
  logic [31:0]             prdata_r;
  logic                    ctrlEn_r;
  logic [`DLR_ST_W-1:0]    mask_r;

  logic                    toneIn;
  logic                    presentRun;
  logic                    absentRun;
  logic                    presentDone;
  logic                    absentDone;

  logic                    evNewDigit;
  logic                    evToneEnd;
  logic                    evReject;

  logic                    setupPh;
  logic                    accessPh;
  logic                    wrAcc;
  logic                    rdAcc;
  logic                    addrHit;
  logic [`DLR_ST_W-1:0]    stSet;
  logic [`DLR_ST_W-1:0]    stClr;
  logic [`DLR_ST_W-1:0]    status;

  // ****************************************************************
  // Tone input gating
  // ****************************************************************
  // Receiver disabled by software looks like silence
  assign toneIn = toneValid & ctrlEn_r;

  // Early steering follows the raw detection with no guard
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      early_r <= 1'b0;
    end else begin
      early_r <= toneIn;
    end
  end

  // ****************************************************************
  // Guard timers
  // ****************************************************************
  // Present guard runs while a new tone is being qualified
  assign presentRun = (state_r == dlr_pkg::PRESENT_WAIT) && toneIn;

  // Absent guard runs while a latched tone is missing
  assign absentRun = (state_r == dlr_pkg::ABSENT_WAIT) && !toneIn;

  // Guard span sits between the reject and accept durations
  dlr_qual_timer #(
    .CYCLES (GUARD_PRESENT_CYC)
  ) u_present_timer (
    .mclk (mclk),
    .rst  (rst),
    .run  (presentRun),
    .done (presentDone)
  );

  // Absent guard also decides what counts as a dropout
  dlr_qual_timer #(
    .CYCLES (GUARD_ABSENT_CYC)
  ) u_absent_timer (
    .mclk (mclk),
    .rst  (rst),
    .run  (absentRun),
    .done (absentDone)
  );

  // ****************************************************************
  // Digit qualification state machine
  // ****************************************************************
  // Next state from tone level and guard expiry
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dlr_pkg::IDLE: begin
        if (toneIn) begin
          state_nxt = dlr_pkg::PRESENT_WAIT;
        end
      end
      dlr_pkg::PRESENT_WAIT: begin
        if (!toneIn) begin
          state_nxt = dlr_pkg::IDLE;
        end else if (presentDone) begin
          state_nxt = dlr_pkg::LATCHED;
        end
      end
      dlr_pkg::LATCHED: begin
        if (!toneIn) begin
          state_nxt = dlr_pkg::ABSENT_WAIT;
        end
      end
      dlr_pkg::ABSENT_WAIT: begin
        if (toneIn) begin
          state_nxt = dlr_pkg::LATCHED;
        end else if (absentDone) begin
          state_nxt = dlr_pkg::IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= dlr_pkg::IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Events
  // ****************************************************************
  // Tone qualified: new digit enters the receive register
  assign evNewDigit = (state_r == dlr_pkg::PRESENT_WAIT) && toneIn && presentDone;

  // Tone absence qualified: end of digit
  assign evToneEnd = (state_r == dlr_pkg::ABSENT_WAIT) && !toneIn && absentDone;

  // Burst dropped before its guard ran out
  assign evReject = (state_r == dlr_pkg::PRESENT_WAIT) && !toneIn;

  // ****************************************************************
  // Receive data register
  // ****************************************************************
  // Only a qualified tone loads the code; otherwise it holds
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      digit_r <= 4'h0;
    end else if (evNewDigit) begin
      digit_r <= toneCode;
    end
  end

  // Four-bit code straight from the register
  assign rxDigitBits = digit_r;

  // ****************************************************************
  // Steering outputs
  // ****************************************************************
  // Delayed steer rises on present guard, falls on absent guard
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      delayed_r <= 1'b0;
    end else if (evNewDigit) begin
      delayed_r <= 1'b1;
    end else if (evToneEnd) begin
      delayed_r <= 1'b0;
    end
  end

  // Guard pin high while presence is timed or held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      guard_r <= 1'b0;
    end else begin
      guard_r <= (state_nxt == dlr_pkg::PRESENT_WAIT) ||
                 (state_nxt == dlr_pkg::LATCHED);
    end
  end

  assign earlyToneFlag = early_r;
  assign delayedSteer  = delayed_r;
  assign steerGuardPin = guard_r;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Zero wait states: every access completes in its first cycle
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrAcc    = accessPh && pwrite;
  assign rdAcc    = accessPh && !pwrite;
  assign pready   = 1'b1;

  // Known word offsets
  assign addrHit = (paddr == `DLR_OFF_RXDATA) ||
                   (paddr == `DLR_OFF_STATUS) ||
                   (paddr == `DLR_OFF_MASK)   ||
                   (paddr == `DLR_OFF_CTRL)   ||
                   (paddr == `DLR_OFF_LEVEL);

  // Unmapped address answers with an error
  assign pslverr = accessPh && !addrHit;

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Hardware events set the sticky bits
  assign stSet[`DLR_ST_NEWDIG]  = evNewDigit;
  assign stSet[`DLR_ST_TONEEND] = evToneEnd;
  assign stSet[`DLR_ST_REJECT]  = evReject;

  // Write one clears; any status read clears the new digit bit
  always_comb begin
    stClr = '0;
    if (wrAcc && (paddr == `DLR_OFF_STATUS)) begin
      stClr = pwdata[`DLR_ST_W-1:0];
    end
    if (rdAcc && (paddr == `DLR_OFF_STATUS)) begin
      stClr[`DLR_ST_NEWDIG] = 1'b1;
    end
  end

  // One sticky cell for each event
  genvar gi;
  generate
    for (gi = 0; gi < `DLR_ST_W; gi++) begin : g_status
      dlr_sticky_flag u_flag (
        .mclk (mclk),
        .rst  (rst),
        .set  (stSet[gi]),
        .clr  (stClr[gi]),
        .flag (status[gi])
      );
    end
  endgenerate

  // Level interrupt from unmasked status
  assign newDigitIrq = |(status & mask_r);

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Interrupt mask
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_r <= `DLR_MASK_RST;
    end else if (wrAcc && (paddr == `DLR_OFF_MASK)) begin
      mask_r <= pwdata[`DLR_ST_W-1:0];
    end
  end

  // Receiver enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlEn_r <= `DLR_CTRL_RST;
    end else if (wrAcc && (paddr == `DLR_OFF_CTRL)) begin
      ctrlEn_r <= pwdata[`DLR_CTRL_EN];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Captured in the setup cycle, held through the access cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0;
    end else if (setupPh && !pwrite) begin
      prdata_r <= 32'h0;
      unique case (paddr)
        `DLR_OFF_RXDATA: begin
          prdata_r[3:0] <= digit_r;
        end
        `DLR_OFF_STATUS: begin
          prdata_r[`DLR_ST_W-1:0] <= status;
        end
        `DLR_OFF_MASK: begin
          prdata_r[`DLR_ST_W-1:0] <= mask_r;
        end
        `DLR_OFF_CTRL: begin
          prdata_r[`DLR_CTRL_EN] <= ctrlEn_r;
        end
        `DLR_OFF_LEVEL: begin
          prdata_r[`DLR_LV_EARLY]   <= early_r;
          prdata_r[`DLR_LV_DELAYED] <= delayed_r;
          prdata_r[`DLR_LV_GUARD]   <= guard_r;
        end
        default: begin
          prdata_r <= 32'h0;
        end
      endcase
    end
  end

  assign prdata = prdata_r;

endmodule

// file: sim/dlr_latch_properties.sv
`timescale 1ns/1ps
`include "dlr_cfg.svh"

// ****************************************************************
// Digit latch properties
// ****************************************************************
module dlr_latch_properties #(
  parameter int unsigned GP = 8,
  parameter int unsigned GA = 8
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        toneValid,
  input wire logic [3:0]  toneCode,
  input wire logic        earlyToneFlag,
  input wire logic        steerGuardPin,
  input wire logic        delayedSteer,
  input wire logic [3:0]  rxDigitBits,
  input wire logic        newDigitIrq,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  int unsigned hiCnt_r;
  int unsigned loCnt_r;
  logic        maskOnly_r;

  // Run lengths of tone and of silence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiCnt_r <= 0;
      loCnt_r <= 0;
    end else begin
      hiCnt_r <= toneValid ? hiCnt_r + 1 : 0;
      loCnt_r <= toneValid ? 0 : loCnt_r + 1;
    end
  end

  // Tracks whether only the new-digit event is unmasked
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      maskOnly_r <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `DLR_OFF_MASK) begin
      maskOnly_r <= (pwdata[2:0] == 3'h1);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence statusRead;
    psel && penable && !pwrite && paddr == `DLR_OFF_STATUS;
  endsequence
  sequence digitLatched;
    $rose(delayedSteer);
  endsequence

  AST_EARLY_FOLLOWS: assert property (earlyToneFlag |-> $past(toneValid))
    else $error("early flag without tone");
  AST_GUARD_START: assert property ($rose(steerGuardPin) |-> $past(toneValid))
    else $error("guard activity without tone");
  AST_RISE_AFTER_GUARD: assert property (digitLatched |-> $past(hiCnt_r) >= GP)
    else $error("delayed steer rose before present guard");
  AST_FALL_AFTER_GUARD: assert property ($fell(delayedSteer) |-> $past(loCnt_r) >= GA)
    else $error("delayed steer fell before absent guard");
  AST_RX_ONLY_ON_LATCH: assert property (!$stable(rxDigitBits) |-> $rose(delayedSteer))
    else $error("digit changed without qualified tone");
  AST_RX_CODE: assert property (digitLatched |-> rxDigitBits == $past(toneCode))
    else $error("latched digit differs from tone code");
  AST_IRQ_ON_DIGIT: assert property (digitLatched ##0 maskOnly_r |-> newDigitIrq)
    else $error("no interrupt on new digit");
  AST_IRQ_CLEAR: assert property (statusRead ##0 maskOnly_r |=> (!newDigitIrq) or digitLatched)
    else $error("interrupt not cleared by status read");
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access not completed");
  AST_UNMAPPED: assert property (psel && penable && paddr > `DLR_OFF_LEVEL |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind dtmf_rx_digit_latch dlr_latch_properties #(
  .GP(GUARD_PRESENT_CYC),
  .GA(GUARD_ABSENT_CYC)
) i_dlr_latch_properties (
  .mclk(mclk), .rst(rst), .toneValid(toneValid), .toneCode(toneCode),
  .earlyToneFlag(earlyToneFlag), .steerGuardPin(steerGuardPin), .delayedSteer(delayedSteer),
  .rxDigitBits(rxDigitBits), .newDigitIrq(newDigitIrq), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr)
);

// file: sim/dlr_tone_src.sv
`timescale 1ns/1ps

// ****************************************************************
// Tone detector front end model
// ****************************************************************
module dlr_tone_src (
  input  wire logic  mclk,
  output logic       toneValid,
  output logic [3:0] toneCode
);
  // Quiet at start
  initial begin
    toneValid = 1'b0;
    toneCode = 4'h0;
  end

  // Tone for hi sampled edges, then silence for lo; idle code is inverted
  task automatic send(input logic [3:0] c, input int hi, input int lo);
    @(posedge mclk);
    toneValid <= 1'b1;
    toneCode <= c;
    repeat (hi - 1) @(posedge mclk);
    @(posedge mclk);
    toneValid <= 1'b0;
    toneCode <= ~c;
    repeat (lo - 1) @(posedge mclk);
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "dlr_cfg.svh"
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module testbench;
  localparam int unsigned GP = 8;
  localparam int unsigned GA = 8;
  logic        mclk, rst, toneValid, psel, penable, pwrite, pready, pslverr, err;
  logic        earlyToneFlag, steerGuardPin, delayedSteer, newDigitIrq;
  logic [3:0]  toneCode, rxDigitBits;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fails, samplesChecked;

  // ****************************************************************
  // Clock, design and tone source
  // ****************************************************************
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  dtmf_rx_digit_latch #(.GUARD_PRESENT_CYC(GP), .GUARD_ABSENT_CYC(GA)) i_dtmf_rx_digit_latch (
    .mclk(mclk), .rst(rst), .toneValid(toneValid), .toneCode(toneCode),
    .earlyToneFlag(earlyToneFlag), .steerGuardPin(steerGuardPin), .delayedSteer(delayedSteer),
    .rxDigitBits(rxDigitBits), .newDigitIrq(newDigitIrq), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  dlr_tone_src i_dlr_tone_src (.mclk(mclk), .toneValid(toneValid), .toneCode(toneCode));

  // ****************************************************************
  // Bus tasks and closing
  // ****************************************************************
  task end_sim;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One APB transfer; read data and error kept in rd and err
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chkRd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(a, 1'b0, 32'h0);
    `CHK(nm, ex, rd)
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task testReset;
    chkRd(`DLR_OFF_MASK, 32'h0, "mask");
    chkRd(`DLR_OFF_CTRL, 32'h1, "ctrl");
    chkRd(`DLR_OFF_STATUS, 32'h0, "status");
    apb(`DLR_OFF_RXDATA, 1'b1, 32'hf);
    chkRd(`DLR_OFF_RXDATA, 32'h0, "rxdata");
    chkRd(`DLR_OFF_LEVEL, 32'h0, "level");
    chkRd(12'h014, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, err)
    `CHK("irq", 1'b0, newDigitIrq)
    $display("reset test done");
  endtask

  task testMask;
    i_dlr_tone_src.send(4'h9, GP + 1, GA + 2);
    `CHK("rx", 4'h9, rxDigitBits)
    `CHK("masked irq", 1'b0, newDigitIrq)
    apb(`DLR_OFF_MASK, 1'b1, 32'h1);
    @(negedge mclk);
    `CHK("unmasked irq", 1'b1, newDigitIrq)
    apb(`DLR_OFF_STATUS, 1'b1, 32'h3);
    @(negedge mclk);
    `CHK("cleared irq", 1'b0, newDigitIrq)
    $display("mask test done");
  endtask

  task testDigits;
    for (int c = 0; c < 16; c++) begin
      i_dlr_tone_src.send(c[3:0], GP + 1, GA + 2);
      // Let the steer fall launched at the last edge settle
      @(negedge mclk);
      `CHK("digit", c[3:0], rxDigitBits)
      `CHK("steer off", 1'b0, delayedSteer)
      `CHK("irq set", 1'b1, newDigitIrq)
      chkRd(`DLR_OFF_STATUS, 32'h3, "status");
      @(negedge mclk);
      `CHK("irq read clear", 1'b0, newDigitIrq)
      apb(`DLR_OFF_STATUS, 1'b1, 32'h2);
    end
    $display("digit test done");
  endtask

  task testShort;
    fork
      i_dlr_tone_src.send(4'h5, GP, GA + 2);
      begin
        repeat (3) @(negedge mclk);
        `CHK("early", 1'b1, earlyToneFlag)
        `CHK("no steer", 1'b0, delayedSteer)
        `CHK("guard", 1'b1, steerGuardPin)
      end
    join
    `CHK("rx kept", 4'hf, rxDigitBits)
    chkRd(`DLR_OFF_STATUS, 32'h4, "reject");
    apb(`DLR_OFF_STATUS, 1'b1, 32'h4);
    $display("short burst test done");
  endtask

  task testDropout;
    i_dlr_tone_src.send(4'h6, GP + 1, GA);
    `CHK("steer held", 1'b1, delayedSteer)
    i_dlr_tone_src.send(4'ha, GP + 1, GA + 2);
    `CHK("rx held", 4'h6, rxDigitBits)
    chkRd(`DLR_OFF_STATUS, 32'h3, "one digit");
    $display("dropout test done");
  endtask

  task testDisable;
    apb(`DLR_OFF_STATUS, 1'b1, 32'h7);
    apb(`DLR_OFF_CTRL, 1'b1, 32'h0);
    i_dlr_tone_src.send(4'h3, GP + 1, GA + 2);
    `CHK("rx disabled", 4'h6, rxDigitBits)
    `CHK("irq disabled", 1'b0, newDigitIrq)
    chkRd(`DLR_OFF_STATUS, 32'h0, "no event");
    apb(`DLR_OFF_CTRL, 1'b1, 32'h1);
    $display("disable test done");
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fails = 0;
    samplesChecked = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    testReset;
    testMask;
    testDigits;
    testShort;
    testDropout;
    testDisable;
    end_sim;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("watchdog expired");
    end_sim;
  end
endmodule
